// file: core/cmpirq_top.sv
// Comparator control, result synchronizer, edge interrupt and Avalon-MM register slave
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`include "cmpirq_params.svh"

module cmpirq_top #(
    parameter int SYNC_STAGES = `CMPIRQ_SYNC_STAGES
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [1:0] AVS_RESPONSE,
    // Analog comparator
    input wire logic COMPARATOR_RAW,
    output cmpirq_pkg::cmpirq_analog_t ANALOG_CTRL,
    // Converter context
    input wire logic CONVERTER_ENABLE,
    input wire logic [5:0] CONVERTER_CHANNEL_SELECT,
    // Processor interrupt
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic IRQ_VECTOR_ACK,
    output logic COMPARATOR_IRQ,
    output logic SYS_IRQ
);

    // =====================================
    // Functions
    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] idx);
        is_reg = (addr == {idx[5:0], 2'b00});
    endfunction

    function automatic logic [7:0] low_byte(input logic [31:0] d, input logic [3:0] be,
                                            input logic [7:0] old);
        low_byte = be[0] ? d[7:0] : old;
    endfunction

    // =====================================
    // Declarations
    logic [7:0] ctl_a_ff;
    logic [7:0] ctl_b_ff;
    logic [`CMPIRQ_EV_W-1:0] imask_ff;
    logic [`CMPIRQ_EV_W-1:0] istat_ff;
    logic [SYNC_STAGES-1:0] sync_ff;
    logic result_prev_ff;
    logic flag_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic result_sync;
    logic rise_ev;
    logic fall_ev;
    logic flag_ev;
    logic acc;
    logic wr_a;
    logic wr_b;
    logic wr_mask;
    logic rd_stat;
    logic mapped;
    logic [7:0] nxt_a;
    logic [7:0] nxt_b;
    logic [31:0] nxt_rdata;
    logic mux_active;
    cmpirq_pkg::cmpirq_mode_t mode;
    cmpirq_pkg::cmpirq_analog_t nxt_analog;

    // =====================================
    // Bus decode: one wait state, answer on second cycle
    assign acc = (AVS_READ | AVS_WRITE) & ~ack_ff;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
    assign mapped = is_reg(AVS_ADDRESS, `CMPIRQ_IDX_CSA) | is_reg(AVS_ADDRESS, `CMPIRQ_IDX_CSB)
        | is_reg(AVS_ADDRESS, `CMPIRQ_IDX_IMASK) | is_reg(AVS_ADDRESS, `CMPIRQ_IDX_ISTAT)
        | is_reg(AVS_ADDRESS, `CMPIRQ_IDX_EXT);
    assign wr_a = acc & AVS_WRITE & is_reg(AVS_ADDRESS, `CMPIRQ_IDX_CSA);
    assign wr_b = acc & AVS_WRITE & is_reg(AVS_ADDRESS, `CMPIRQ_IDX_CSB);
    assign wr_mask = acc & AVS_WRITE & is_reg(AVS_ADDRESS, `CMPIRQ_IDX_IMASK);
    assign rd_stat = acc & AVS_READ & is_reg(AVS_ADDRESS, `CMPIRQ_IDX_ISTAT);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            AVS_RESPONSE <= 2'h0;
        end else if (acc) begin
            AVS_RESPONSE <= mapped ? 2'h0 : 2'h3;
        end
    end

    // =====================================
    // Result synchronizer
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= {sync_ff[SYNC_STAGES-2:0], COMPARATOR_RAW};
        end
    end

    assign result_sync = sync_ff[SYNC_STAGES-1];

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            result_prev_ff <= 1'b0;
        end else begin
            result_prev_ff <= result_sync;
        end
    end

    // =====================================
    // Edge selection
    assign rise_ev = result_sync & ~result_prev_ff;
    assign fall_ev = ~result_sync & result_prev_ff;
    assign mode = cmpirq_pkg::cmpirq_mode_t'(ctl_a_ff[`CMPIRQ_A_MODE_HI:`CMPIRQ_A_MODE_LO]);

    always_comb begin
        case (mode)
            cmpirq_pkg::CMPIRQ_MODE_TOGGLE: flag_ev = rise_ev | fall_ev;
            cmpirq_pkg::CMPIRQ_MODE_FALL: flag_ev = fall_ev;
            cmpirq_pkg::CMPIRQ_MODE_RISE: flag_ev = rise_ev;
            default: flag_ev = 1'b0;
        endcase
    end

    // =====================================
    // Comparator interrupt flag, set wins over clear
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            flag_ff <= 1'b0;
        end else if (flag_ev) begin
            flag_ff <= 1'b1;
        end else if (IRQ_VECTOR_ACK) begin
            flag_ff <= 1'b0;
        end else if (wr_a & AVS_BYTEENABLE[0] & AVS_WRITEDATA[`CMPIRQ_A_FLAG]) begin
            flag_ff <= 1'b0;
        end
    end

    assign COMPARATOR_IRQ = flag_ff & ctl_a_ff[`CMPIRQ_A_IE] & GLOBAL_IRQ_ENABLE;

    // =====================================
    // Control register A
    always_comb begin
        nxt_a = low_byte(AVS_WRITEDATA, AVS_BYTEENABLE, ctl_a_ff);
        nxt_a[`CMPIRQ_A_RES] = 1'b0;
        nxt_a[`CMPIRQ_A_FLAG] = 1'b0;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ctl_a_ff <= `CMPIRQ_RST_A;
        end else if (wr_a) begin
            ctl_a_ff <= nxt_a;
        end
    end

    // =====================================
    // Control register B
    always_comb begin
        nxt_b = low_byte(AVS_WRITEDATA, AVS_BYTEENABLE, ctl_b_ff) & `CMPIRQ_B_WMASK;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ctl_b_ff <= `CMPIRQ_RST_B;
        end else if (wr_b) begin
            ctl_b_ff <= nxt_b;
        end
    end

    // =====================================
    // System interrupt: sticky events, mask, clear on read
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            imask_ff <= `CMPIRQ_RST_EV;
        end else if (wr_mask & AVS_BYTEENABLE[0]) begin
            imask_ff <= AVS_WRITEDATA[`CMPIRQ_EV_W-1:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            istat_ff <= `CMPIRQ_RST_EV;
        end else begin
            istat_ff <= (rd_stat ? `CMPIRQ_RST_EV : istat_ff)
                | {fall_ev, rise_ev, flag_ev};
        end
    end

    assign SYS_IRQ = |(istat_ff & imask_ff);

    // =====================================
    // Read data
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (is_reg(AVS_ADDRESS, `CMPIRQ_IDX_CSA)) begin
            nxt_rdata[7:0] = ctl_a_ff;
            nxt_rdata[`CMPIRQ_A_RES] = result_sync;
            nxt_rdata[`CMPIRQ_A_FLAG] = flag_ff;
        end else if (is_reg(AVS_ADDRESS, `CMPIRQ_IDX_CSB)) begin
            nxt_rdata[7:0] = ctl_b_ff;
        end else if (is_reg(AVS_ADDRESS, `CMPIRQ_IDX_IMASK)) begin
            nxt_rdata[`CMPIRQ_EV_W-1:0] = imask_ff;
        end else if (is_reg(AVS_ADDRESS, `CMPIRQ_IDX_ISTAT)) begin
            nxt_rdata[`CMPIRQ_EV_W-1:0] = istat_ff;
        end else if (is_reg(AVS_ADDRESS, `CMPIRQ_IDX_EXT)) begin
            nxt_rdata[0] = CONVERTER_ENABLE;
            nxt_rdata[13:8] = CONVERTER_CHANNEL_SELECT;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rdata_ff <= 32'h0000_0000;
        end else if (acc & AVS_READ) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign AVS_READDATA = rdata_ff;

    // =====================================
    // Analog input steering
    assign mux_active = ctl_a_ff[`CMPIRQ_A_MUXEN] & ~CONVERTER_ENABLE
        & (CONVERTER_CHANNEL_SELECT <= `CMPIRQ_CHAN_MAX);

    always_comb begin
        nxt_analog = '0;
        nxt_analog.power_off = ctl_a_ff[`CMPIRQ_A_OFF];
        nxt_analog.bandgap_sel = ctl_a_ff[`CMPIRQ_A_BG];
        nxt_analog.hys_en = ctl_b_ff[`CMPIRQ_B_HYS];
        nxt_analog.hys_level = ctl_b_ff[`CMPIRQ_B_HYSTERESIS_LEVEL];
        if (mux_active) begin
            nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_CONV;
            nxt_analog.neg_conv_chan = CONVERTER_CHANNEL_SELECT;
            case (ctl_b_ff[`CMPIRQ_B_PAIR_HI:`CMPIRQ_B_PAIR_LO])
                3'h0: nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ZERO;
                3'h2, 3'h3: nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ONE;
                3'h4, 3'h5, 3'h6, 3'h7: nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_TWO;
                default: nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ZERO;
            endcase
        end else begin
            case (ctl_b_ff[`CMPIRQ_B_PAIR_HI:`CMPIRQ_B_PAIR_LO])
                3'h0: begin
                    nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ZERO;
                    nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_ONE;
                end
                3'h1: begin
                    nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ZERO;
                    nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_TWO;
                end
                3'h2: begin
                    nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ONE;
                    nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_ZERO;
                end
                3'h3: begin
                    nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_ONE;
                    nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_TWO;
                end
                3'h4: begin
                    nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_TWO;
                    nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_ZERO;
                end
                default: begin
                    nxt_analog.pos_pin = cmpirq_pkg::CMPIRQ_PIN_TWO;
                    nxt_analog.neg_pin = cmpirq_pkg::CMPIRQ_PIN_ONE;
                end
            endcase
        end
    end

    // Analog steering from flip-flops
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ANALOG_CTRL <= '0;
        end else begin
            ANALOG_CTRL <= nxt_analog;
        end
    end

endmodule

// file: pkg/cmpirq_params.svh
// Register offsets, field positions, reset values and timing for the comparator control block
`ifndef CMPIRQ_PARAMS_SVH
`define CMPIRQ_PARAMS_SVH

// =====================================
// Register map (printed offsets are word indices, bus address is four times)
`define CMPIRQ_IDX_CSA 8'h08
`define CMPIRQ_IDX_CSB 8'h09
`define CMPIRQ_IDX_IMASK 8'h0A
`define CMPIRQ_IDX_ISTAT 8'h0B
`define CMPIRQ_IDX_EXT 8'h0C

// =====================================
// Register A fields
`define CMPIRQ_A_OFF 7
`define CMPIRQ_A_BG 6
`define CMPIRQ_A_RES 5
`define CMPIRQ_A_FLAG 4
`define CMPIRQ_A_IE 3
`define CMPIRQ_A_MUXEN 2
`define CMPIRQ_A_MODE_HI 1
`define CMPIRQ_A_MODE_LO 0

// =====================================
// Register B fields
`define CMPIRQ_B_HYS 7
`define CMPIRQ_B_HYSTERESIS_LEVEL 6
`define CMPIRQ_B_PAIR_HI 2
`define CMPIRQ_B_PAIR_LO 0
`define CMPIRQ_B_WMASK 8'hC7

// =====================================
// Interrupt status bits
`define CMPIRQ_EV_EDGE 0
`define CMPIRQ_EV_RISE 1
`define CMPIRQ_EV_FALL 2
`define CMPIRQ_EV_W 3

// =====================================
// Reset values and timing
`define CMPIRQ_RST_A 8'h00
`define CMPIRQ_RST_B 8'h00
`define CMPIRQ_RST_EV 3'h0
`define CMPIRQ_SYNC_STAGES 2
`define CMPIRQ_CHAN_MAX 6'h0A
`define CMPIRQ_HYS_LOW_MV 20
`define CMPIRQ_HYS_HIGH_MV 50

`endif

// file: pkg/cmpirq_pkg.sv
// Types shared by the comparator control block
package cmpirq_pkg;

    // =====================================
    // Interrupt event modes
    typedef enum logic [1:0] {
        CMPIRQ_MODE_TOGGLE,
        CMPIRQ_MODE_RSVD,
        CMPIRQ_MODE_FALL,
        CMPIRQ_MODE_RISE
    } cmpirq_mode_t;

    // =====================================
    // Pin identifiers for the analog input switches
    typedef enum logic [1:0] {
        CMPIRQ_PIN_ZERO,
        CMPIRQ_PIN_ONE,
        CMPIRQ_PIN_TWO,
        CMPIRQ_PIN_CONV
    } cmpirq_pin_t;

    // =====================================
    // Analog front-end steering
    typedef struct packed {
        logic power_off;
        logic bandgap_sel;
        cmpirq_pin_t pos_pin;
        cmpirq_pin_t neg_pin;
        logic [5:0] neg_conv_chan;
        logic hys_en;
        logic hys_level;
    } cmpirq_analog_t;

endpackage

// file: tb/cmpirq_analog_model.sv
// Behavioural analog comparator facing the control block
`timescale 1ns/10ps
module cmpirq_analog_model (
    // Steering from the block
    input wire cmpirq_pkg::cmpirq_analog_t CTRL,
    // Voltages in millivolts
    input wire logic [11:0] PIN_MV [3],
    input wire logic [11:0] CONV_MV [11],
    // Raw result
    output logic RAW
);
    int pos;
    int neg;
    int hys;
    always @* begin
        pos = CTRL.bandgap_sel ? 1100 : int'(PIN_MV[CTRL.pos_pin]);
        neg = (CTRL.neg_pin == cmpirq_pkg::CMPIRQ_PIN_CONV) ?
            int'(CONV_MV[CTRL.neg_conv_chan]) : int'(PIN_MV[CTRL.neg_pin]);
        hys = CTRL.hys_en ? (CTRL.hys_level ? 50 : 20) : 0;
        if (CTRL.power_off) begin
            RAW = 1'b0;
        end else if (pos > neg + hys) begin
            RAW = 1'b1;
        end else if (pos + hys <= neg) begin
            RAW = 1'b0;
        end
    end
endmodule

// file: tb/cmpirq_asserts.sv
// Port assertions and covers for the comparator control block
`timescale 1ns/10ps
module cmpirq_asserts #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // Register bus
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Comparator and interrupt
    input wire logic COMPARATOR_RAW,
    input wire cmpirq_pkg::cmpirq_analog_t ANALOG_CTRL,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic IRQ_VECTOR_ACK,
    input wire logic COMPARATOR_IRQ
);
    // =====================================
    // Shadow registers and quiet counter
    logic [7:0] a_ff;
    logic [7:0] b_ff;
    logic [2:0] quiet_ff;
    logic done;
    assign done = AVS_WRITE & !AVS_WAITREQUEST;
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            a_ff <= 8'h00;
            b_ff <= 8'h00;
        end else if (done && AVS_ADDRESS == 8'h20) begin
            a_ff <= AVS_WRITEDATA[7:0];
        end else if (done && AVS_ADDRESS == 8'h24) begin
            b_ff <= AVS_WRITEDATA[7:0];
        end
    end
    always_ff @(posedge MCLK) begin
        if (RESET || $changed(COMPARATOR_RAW)) begin
            quiet_ff <= 3'h0;
        end else if (quiet_ff != 3'h7) begin
            quiet_ff <= quiet_ff + 3'h1;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // =====================================
    // Properties
    property p_wait;
        $rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer timing wrong");
    property p_rise;
        $rose(COMPARATOR_RAW) && a_ff[1:0] == 2'h3 && a_ff[3] && GLOBAL_IRQ_ENABLE
            |-> ##[1:4] COMPARATOR_IRQ;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge gave no irq");
    property p_toggle;
        $changed(COMPARATOR_RAW) && a_ff[1:0] == 2'h0 && a_ff[3] && GLOBAL_IRQ_ENABLE
            |-> ##[1:4] COMPARATOR_IRQ;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle gave no irq");
    property p_wrong;
        (($rose(COMPARATOR_RAW) && a_ff[1:0] inside {2'h1, 2'h2}) ||
         ($fell(COMPARATOR_RAW) && a_ff[1:0] inside {2'h1, 2'h3})) && !COMPARATOR_IRQ
            |=> !COMPARATOR_IRQ [*4];
    endproperty
    a_wrong: assert property (p_wrong) else $error("irq on wrong edge");
    property p_gate;
        COMPARATOR_IRQ && !AVS_WRITE |-> GLOBAL_IRQ_ENABLE && a_ff[3];
    endproperty
    a_gate: assert property (p_gate) else $error("irq without enables");
    property p_ack;
        IRQ_VECTOR_ACK && quiet_ff > 3'h4 |=> !COMPARATOR_IRQ;
    endproperty
    a_ack: assert property (p_ack) else $error("vector entry left irq");
    property p_ctl_a;
        ANALOG_CTRL.power_off == a_ff[7] && ANALOG_CTRL.bandgap_sel == a_ff[6];
    endproperty
    a_ctl_a: assert property (p_ctl_a) else $error("power or bandgap wrong");
    property p_ctl_b;
        ANALOG_CTRL.hys_en == b_ff[7] && (!b_ff[7] || ANALOG_CTRL.hys_level == b_ff[6]);
    endproperty
    a_ctl_b: assert property (p_ctl_b) else $error("hysteresis wrong");
    property p_resv;
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h24 |-> AVS_READDATA[5:3] == 3'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    c_irq: cover property (COMPARATOR_IRQ && a_ff[1:0] == 2'h3);
    c_ack: cover property (IRQ_VECTOR_ACK && COMPARATOR_IRQ);
    c_mux: cover property (ANALOG_CTRL.neg_pin == cmpirq_pkg::CMPIRQ_PIN_CONV);
endmodule
bind cmpirq_top cmpirq_asserts #(.SYNC_STAGES(SYNC_STAGES)) cmpirq_asserts_inst (
    .MCLK(MCLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .COMPARATOR_RAW(COMPARATOR_RAW),
    .ANALOG_CTRL(ANALOG_CTRL), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .COMPARATOR_IRQ(COMPARATOR_IRQ));

// file: tb/tb_cmpirq_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module tb_cmpirq_top;
    // =====================================
    // Signals
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic [1:0] resp;
    logic raw;
    cmpirq_pkg::cmpirq_analog_t actl;
    logic conv_en = 1'b0;
    logic [5:0] chan = 6'h00;
    logic gie = 1'b1;
    logic ack = 1'b0;
    logic cirq;
    logic sirq;
    logic [11:0] pin_mv [3] = '{12'h000, 12'h000, 12'h000};
    logic [11:0] conv_mv [11] = '{default: 12'h000};
    logic [1:0] pos_tab [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
    logic [1:0] neg_tab [8] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1, 2'h1};
    logic [31:0] q;
    logic [1:0] last_resp;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    cmpirq_top cmpirq_top_inst (.MCLK(mclk), .RESET(reset), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp), .COMPARATOR_RAW(raw), .ANALOG_CTRL(actl),
        .CONVERTER_ENABLE(conv_en), .CONVERTER_CHANNEL_SELECT(chan), .GLOBAL_IRQ_ENABLE(gie),
        .IRQ_VECTOR_ACK(ack), .COMPARATOR_IRQ(cirq), .SYS_IRQ(sirq));
    cmpirq_analog_model cmpirq_analog_model_inst (.CTRL(actl), .PIN_MV(pin_mv),
        .CONV_MV(conv_mv), .RAW(raw));
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // =====================================
    // Shared tasks
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h000000, d};
        @(posedge mclk);
        while (wreq !== 1'b0) begin
            @(posedge mclk);
        end
        q = rdat;
        last_resp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // =====================================
    // Scenarios
    task automatic t_regs();
        bus(1'b0, 8'h20, 8'h00);
        chk(q, 32'h0);
        bus(1'b1, 8'h24, 8'hFF);
        bus(1'b0, 8'h24, 8'h00);
        chk(q, 32'hC7);
        chk({30'h0, actl.hys_en, actl.hys_level}, 32'h3);
        bus(1'b1, 8'h24, 8'h80);
        @(negedge mclk);
        chk({30'h0, actl.hys_en, actl.hys_level}, 32'h2);
        bus(1'b1, 8'h3C, 8'hFF);
        bus(1'b0, 8'h3C, 8'h00);
        chk({q[29:0], last_resp}, 32'h3);
    endtask
    task automatic t_pairs();
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h24, i[7:0]);
            @(negedge mclk);
            chk({28'h0, actl.pos_pin, actl.neg_pin}, {28'h0, pos_tab[i], neg_tab[i]});
        end
        bus(1'b1, 8'h20, 8'h04);
        for (int c = 0; c < 12; c++) begin
            @(posedge mclk);
            chan <= c[5:0];
            bus(1'b1, 8'h24, {5'h00, c[2:0]});
            @(negedge mclk);
            if (c < 11) begin
                chk({22'h0, actl.pos_pin, actl.neg_pin, actl.neg_conv_chan},
                    {22'h0, pos_tab[c[2:0]], 2'h3, c[5:0]});
            end else begin
                chk({30'h0, actl.neg_pin}, {30'h0, neg_tab[c[2:0]]});
            end
        end
        @(posedge mclk);
        conv_en <= 1'b1;
        chan <= 6'h05;
        bus(1'b1, 8'h24, 8'h00);
        @(negedge mclk);
        chk({30'h0, actl.neg_pin}, 32'h1);
        bus(1'b0, 8'h30, 8'h00);
        chk(q, 32'h0000_0501);
    endtask
    task automatic t_modes();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            bus(1'b1, 8'h20, {6'h04, m});
            bus(1'b1, 8'h20, {6'h02, m});
            pin_mv[0] <= 12'h300;
            repeat (6) @(posedge mclk);
            chk({31'h0, cirq}, {31'h0, m == 2'h0 || m == 2'h3});
            ack <= 1'b1;
            @(posedge mclk);
            ack <= 1'b0;
            @(negedge mclk);
            chk({31'h0, cirq}, 32'h0);
            @(posedge mclk);
            pin_mv[0] <= 12'h000;
            repeat (6) @(posedge mclk);
            chk({31'h0, cirq}, {31'h0, m == 2'h0 || m == 2'h2});
            bus(1'b1, 8'h20, {6'h06, m});
            chk({31'h0, cirq}, 32'h0);
            bus(1'b1, 8'h20, {6'h00, m});
        end
    endtask
    task automatic t_irq();
        bus(1'b1, 8'h20, 8'h1B);
        gie <= 1'b0;
        pin_mv[0] <= 12'h300;
        repeat (6) @(posedge mclk);
        chk({31'h0, cirq}, 32'h0);
        gie <= 1'b1;
        @(negedge mclk);
        chk({31'h0, cirq}, 32'h1);
        bus(1'b1, 8'h20, 8'h03);
        chk({31'h0, cirq}, 32'h0);
        bus(1'b0, 8'h2C, 8'h00);
        bus(1'b1, 8'h28, 8'h04);
        pin_mv[0] <= 12'h000;
        repeat (6) @(posedge mclk);
        chk({31'h0, sirq}, 32'h1);
        bus(1'b0, 8'h2C, 8'h00);
        chk(q, 32'h4);
        chk({31'h0, sirq}, 32'h0);
        pin_mv[0] <= 12'h300;
        repeat (6) @(posedge mclk);
        chk({31'h0, sirq}, 32'h0);
        bus(1'b0, 8'h2C, 8'h00);
        chk(q, 32'h3);
        bus(1'b0, 8'h20, 8'h00);
        chk(q, 32'h33);
        bus(1'b1, 8'h20, 8'hC3);
        @(negedge mclk);
        chk({30'h0, actl.power_off, actl.bandgap_sel}, 32'h3);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_regs();
        t_pairs();
        t_modes();
        t_irq();
        report_and_stop();
    end
endmodule
